//--- hw/port_e_ready_pin_mux.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
// Function
// RL1: Select bits 1..7 choose general-purpose or alternate use per pin.
// RL2: An unselected pin is a bidirectional general-purpose bit.
// RL3: Timer 1 overflow output pulses high one clock per overflow.
// RL4: In timer 1 split mode, the low-byte overflow drives the pulse.
// RL5: Timer 2 overflow output pulses high one clock per overflow.
// RL6: Serial 0 pin carries sync data in mode 0, else drives 1.
// RL7: Serial 1 pin carries sync data in mode 0.
// RL8: Serial 1 pin is held high in modes 1, 2 and 3.
// RL9: Interrupt 6 input registers a request on a rising edge.
// RL10: A falling edge on the timer 2 external input reloads timer 2.
// RL11: The timer 2 external input is ignored unless enabled.
// RL12: Port bit 7 alternate use drives waveform address bit 8.
// RL13: Interface mode field picks ready inputs or slave-FIFO strobes.
// RL14: In FIFO mode ready 0 is a read strobe, polarity bit 3.
// RL15: In FIFO mode ready 1 is a write strobe, polarity bit 2.
// RL16: Ready 2 to 5 are inputs sampled by the waveform interface.
// RL17: Select value 1 means alternate; all configuration clears on reset.
module port_e_ready_pin_mux (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire port_e_mux_pkg::core_alt_type coreAlt,
	input  wire logic [7:1]                  portPinIn,
	output logic      [7:1]                  portPinOut,
	output logic      [7:1]                  portPinOe,
	input  wire logic [5:0]                  readyPinIn,
	output logic      [5:0]                  readyLevels,
	output logic                             slaveReadStrobe,
	output logic                             slaveWriteStrobe,
	output logic                             irq6Request,
	output logic                             timer2Reload
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:1]  altSelect_q, gpioOut_q, gpioDir_q, pinOut_q, pinOe_q;
	logic [7:1]  portLevel;
	logic [1:0]  ifMode_q, edgeRise, edgeFall;
	logic [5:0]  readyLevels_q, readyLevel;
	logic [12:0] syncLevel;
	logic [31:0] prdata_q, readData_d;
	logic        polRead_q, polWrite_q, extEnable_q, irq6Seen_q;
	logic        reloadSeen_q, slaveRead_q, slaveWrite_q, irq6Request_q;
	logic        timer2Reload_q, pready_q, pslverr_q, addrHit_d, writeEn;
	logic        statusWrite, fifoMode, irq6Event, reloadEvent;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic regHit(input logic [7:0] addr,
		input logic [7:0] ofs);
		regHit = (addr == ofs);
	endfunction : regHit
	// Serial pin: sync data in mode 0, idle high otherwise
	function automatic logic serialPin(input logic [1:0] mode,
		input logic data);
		serialPin = (mode == port_e_mux_pkg::SERIAL_MODE_SYNC) ?
			data : 1'b1;
	endfunction : serialPin

	// ----------------------------------------------------------------
	// Input synchronisers and edge detection
	// ----------------------------------------------------------------
	input_sync #(
		.WIDTH    (13)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.pinLevel ({readyPinIn, portPinIn}),
		.level    (syncLevel)
	);
	assign portLevel  = syncLevel[6:0];
	assign readyLevel = syncLevel[12:7];
	edge_detect #(
		.WIDTH (2)
	) u_edge (
		.clk   (clk),
		.reset (reset),
		.level (portLevel[port_e_mux_pkg::PIN_RELOAD:
			port_e_mux_pkg::PIN_IRQ6]),
		.rise  (edgeRise),
		.fall  (edgeFall)
	);

	// Pin events only count while the pin carries its alternate use
	assign irq6Event = altSelect_q[port_e_mux_pkg::PIN_IRQ6] &
		edgeRise[0]; // [RL9]
	assign reloadEvent = altSelect_q[port_e_mux_pkg::PIN_RELOAD] &
		extEnable_q & edgeFall[1]; // [RL10] [RL11]
	assign fifoMode = (ifMode_q ==
		port_e_mux_pkg::IF_MODE_SLAVE_FIFO); // [RL13]

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign writeEn = psel & penable & pwrite & pready_q;
	assign statusWrite = writeEn &
		regHit(paddr, port_e_mux_pkg::EVENT_STATUS_OFS);
	// Read decode
	always_comb begin
		readData_d = '0;
		addrHit_d  = 1'b1;
		unique case (1'b1)
			regHit(paddr, port_e_mux_pkg::ALT_SELECT_OFS):
				readData_d[7:1] = altSelect_q;
			regHit(paddr, port_e_mux_pkg::GPIO_OUT_OFS):
				readData_d[7:1] = gpioOut_q;
			regHit(paddr, port_e_mux_pkg::GPIO_DIR_OFS):
				readData_d[7:1] = gpioDir_q;
			regHit(paddr, port_e_mux_pkg::GPIO_IN_OFS):
				readData_d[7:1] = portLevel;
			regHit(paddr, port_e_mux_pkg::IF_CONFIG_OFS):
				readData_d[1:0] = ifMode_q;
			regHit(paddr, port_e_mux_pkg::FIFO_POLARITY_OFS): begin
				readData_d[port_e_mux_pkg::POL_READ]  = polRead_q;
				readData_d[port_e_mux_pkg::POL_WRITE] = polWrite_q;
			end
			regHit(paddr, port_e_mux_pkg::TIMER2_CTRL_OFS):
				readData_d[port_e_mux_pkg::T2_EXT_EN] = extEnable_q;
			regHit(paddr, port_e_mux_pkg::EVENT_STATUS_OFS): begin
				readData_d[port_e_mux_pkg::STAT_IRQ6]   = irq6Seen_q;
				readData_d[port_e_mux_pkg::STAT_RELOAD] = reloadSeen_q;
			end
			default:
				addrHit_d = 1'b0;
		endcase
	end

	// Answer one cycle into the access phase
	always_ff @(posedge clk) begin
		if (reset || !(psel && penable && !pready_q)) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= 1'b1;
			prdata_q  <= pwrite ? '0 : readData_d;
			pslverr_q <= !addrHit_d;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			altSelect_q <= port_e_mux_pkg::PORT_RESET; // [RL17]
			gpioOut_q   <= port_e_mux_pkg::PORT_RESET;
			gpioDir_q   <= port_e_mux_pkg::PORT_RESET;
			ifMode_q    <= port_e_mux_pkg::MODE_RESET;
			polRead_q   <= 1'b0;
			polWrite_q  <= 1'b0;
			extEnable_q <= 1'b0;
		end else if (writeEn) begin
			if (regHit(paddr, port_e_mux_pkg::ALT_SELECT_OFS))
				altSelect_q <= pwdata[7:1]; // [RL1]
			if (regHit(paddr, port_e_mux_pkg::GPIO_OUT_OFS))
				gpioOut_q <= pwdata[7:1];
			if (regHit(paddr, port_e_mux_pkg::GPIO_DIR_OFS))
				gpioDir_q <= pwdata[7:1];
			if (regHit(paddr, port_e_mux_pkg::IF_CONFIG_OFS))
				ifMode_q <= pwdata[1:0]; // [RL13]
			if (regHit(paddr, port_e_mux_pkg::FIFO_POLARITY_OFS)) begin
				polRead_q  <= pwdata[port_e_mux_pkg::POL_READ];
				polWrite_q <= pwdata[port_e_mux_pkg::POL_WRITE];
			end
			if (regHit(paddr, port_e_mux_pkg::TIMER2_CTRL_OFS))
				extEnable_q <= pwdata[port_e_mux_pkg::T2_EXT_EN];
		end
	end

	// Sticky event flags, write one to clear; a new event wins
	always_ff @(posedge clk) begin
		if (reset) begin
			irq6Seen_q   <= 1'b0;
			reloadSeen_q <= 1'b0;
		end else begin
			irq6Seen_q   <= irq6Event | (irq6Seen_q &
				~(statusWrite & pwdata[port_e_mux_pkg::STAT_IRQ6]));
			reloadSeen_q <= reloadEvent | (reloadSeen_q &
				~(statusWrite & pwdata[port_e_mux_pkg::STAT_RELOAD]));
		end
	end

	// ----------------------------------------------------------------
	// Port pin multiplexer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			pinOut_q <= port_e_mux_pkg::PORT_RESET;
			pinOe_q  <= port_e_mux_pkg::PORT_RESET;
		end else begin
			// General-purpose defaults for every pin
			pinOut_q <= gpioOut_q; // [RL2]
			pinOe_q  <= gpioDir_q; // [RL2]
			if (altSelect_q[port_e_mux_pkg::PIN_T1OVF]) begin // [RL1]
				pinOut_q[port_e_mux_pkg::PIN_T1OVF] <=
					(coreAlt.timer1Mode == port_e_mux_pkg::TIMER_MODE_SPLIT) ?
					coreAlt.timer1LowOverflow :
					coreAlt.timer1Overflow; // [RL3] [RL4]
				pinOe_q[port_e_mux_pkg::PIN_T1OVF] <= 1'b1;
			end
			if (altSelect_q[port_e_mux_pkg::PIN_T2OVF]) begin
				pinOut_q[port_e_mux_pkg::PIN_T2OVF] <=
					coreAlt.timer2Overflow; // [RL5]
				pinOe_q[port_e_mux_pkg::PIN_T2OVF] <= 1'b1;
			end
			if (altSelect_q[port_e_mux_pkg::PIN_SER0]) begin
				pinOut_q[port_e_mux_pkg::PIN_SER0] <= serialPin(
					coreAlt.serial0Mode, coreAlt.serial0Data); // [RL6]
				pinOe_q[port_e_mux_pkg::PIN_SER0] <= 1'b1;
			end
			if (altSelect_q[port_e_mux_pkg::PIN_SER1]) begin
				pinOut_q[port_e_mux_pkg::PIN_SER1] <= serialPin(
					coreAlt.serial1Mode, coreAlt.serial1Data); // [RL7] [RL8]
				pinOe_q[port_e_mux_pkg::PIN_SER1] <= 1'b1;
			end
			// Input-only alternates release the pin
			if (altSelect_q[port_e_mux_pkg::PIN_IRQ6]) begin
				pinOut_q[port_e_mux_pkg::PIN_IRQ6] <= 1'b0;
				pinOe_q[port_e_mux_pkg::PIN_IRQ6]  <= 1'b0;
			end
			if (altSelect_q[port_e_mux_pkg::PIN_RELOAD]) begin
				pinOut_q[port_e_mux_pkg::PIN_RELOAD] <= 1'b0;
				pinOe_q[port_e_mux_pkg::PIN_RELOAD]  <= 1'b0;
			end
			if (altSelect_q[port_e_mux_pkg::PIN_ADDR8]) begin
				pinOut_q[port_e_mux_pkg::PIN_ADDR8] <=
					coreAlt.waveformAddr8; // [RL12]
				pinOe_q[port_e_mux_pkg::PIN_ADDR8] <= 1'b1;
			end
		end
	end

	// Pin events towards the core
	always_ff @(posedge clk) begin
		if (reset) begin
			irq6Request_q  <= 1'b0;
			timer2Reload_q <= 1'b0;
		end else begin
			irq6Request_q  <= irq6Event; // [RL9]
			timer2Reload_q <= reloadEvent; // [RL10] [RL11]
		end
	end

	// ----------------------------------------------------------------
	// Ready pins and slave-FIFO strobes
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			readyLevels_q <= port_e_mux_pkg::READY_RESET;
			slaveRead_q   <= 1'b0;
			slaveWrite_q  <= 1'b0;
		end else begin
			readyLevels_q[5:2] <= readyLevel[5:2]; // [RL16]
			readyLevels_q[1:0] <= fifoMode ? 2'h0 : readyLevel[1:0];
			slaveRead_q  <= fifoMode &
				(readyLevel[0] == polRead_q); // [RL14]
			slaveWrite_q <= fifoMode &
				(readyLevel[1] == polWrite_q); // [RL15]
		end
	end

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign portPinOut       = pinOut_q;
	assign portPinOe        = pinOe_q;
	assign readyLevels      = readyLevels_q;
	assign slaveReadStrobe  = slaveRead_q;
	assign slaveWriteStrobe = slaveWrite_q;
	assign irq6Request      = irq6Request_q;
	assign timer2Reload     = timer2Reload_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_gpio_when_off: // [RL2]
	assert property (!altSelect_q[port_e_mux_pkg::PIN_IRQ6] |=>
		portPinOe[5] == $past(gpioDir_q[5]) &&
		portPinOut[5] == $past(gpioOut_q[5]))
		else $error("unselected pin not driven as general-purpose");
	a_t1_split_pulse: // [RL4]
	assert property (altSelect_q[1] &&
		coreAlt.timer1Mode == port_e_mux_pkg::TIMER_MODE_SPLIT &&
		coreAlt.timer1LowOverflow |=> portPinOut[1] && portPinOe[1])
		else $error("split-mode low overflow not on pin");
	a_t1_no_pulse: // [RL3]
	assert property (altSelect_q[1] && !coreAlt.timer1Overflow &&
		!coreAlt.timer1LowOverflow |=> !portPinOut[1])
		else $error("timer 1 pin high without overflow");
	a_t2_pulse_pin: // [RL5]
	assert property (altSelect_q[2] |=>
		portPinOut[2] == $past(coreAlt.timer2Overflow))
		else $error("timer 2 pulse not on pin");
	a_ser0_idle_high: // [RL6]
	assert property (altSelect_q[3] && coreAlt.serial0Mode !=
		port_e_mux_pkg::SERIAL_MODE_SYNC |=> portPinOut[3])
		else $error("serial 0 pin not high outside mode 0");
	a_ser1_sync_data: // [RL7]
	assert property (altSelect_q[4] && coreAlt.serial1Mode ==
		port_e_mux_pkg::SERIAL_MODE_SYNC |=>
		portPinOut[4] == $past(coreAlt.serial1Data))
		else $error("serial 1 sync data not on pin");
	a_irq6_on_rise: // [RL9]
	assert property (irq6Request |->
		$past(altSelect_q[5]) && $past(portLevel[5]) &&
		!$past(portLevel[5], 2))
		else $error("interrupt 6 request without rising edge");
	a_reload_gated: // [RL11]
	assert property (!extEnable_q |=> !timer2Reload)
		else $error("reload while external input disabled");
	a_read_strobe_pol: // [RL14]
	assert property (fifoMode && readyLevel[0] == polRead_q |=>
		slaveReadStrobe && readyLevels[0] == 1'b0)
		else $error("read strobe not asserted at set polarity");
	a_ready_pass: // [RL16]
	assert property (##1 readyLevels[5:2] == $past(readyLevel[5:2]))
		else $error("ready 2..5 not passed through");
	a_apb_answer:
	assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered next cycle");

endmodule : port_e_ready_pin_mux

//--- pkg/port_e_mux_pkg.sv
package port_e_mux_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ALT_SELECT_OFS    = 8'h00;
	localparam logic [7:0] GPIO_OUT_OFS      = 8'h04;
	localparam logic [7:0] GPIO_DIR_OFS      = 8'h08;
	localparam logic [7:0] GPIO_IN_OFS       = 8'h0c;
	localparam logic [7:0] IF_CONFIG_OFS     = 8'h10;
	localparam logic [7:0] FIFO_POLARITY_OFS = 8'h14;
	localparam logic [7:0] TIMER2_CTRL_OFS   = 8'h18;
	localparam logic [7:0] EVENT_STATUS_OFS  = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int PIN_T1OVF   = 1;
	localparam int PIN_T2OVF   = 2;
	localparam int PIN_SER0    = 3;
	localparam int PIN_SER1    = 4;
	localparam int PIN_IRQ6    = 5;
	localparam int PIN_RELOAD  = 6;
	localparam int PIN_ADDR8   = 7;
	localparam int POL_READ    = 3;
	localparam int POL_WRITE   = 2;
	localparam int T2_EXT_EN   = 3;
	localparam int STAT_IRQ6   = 0;
	localparam int STAT_RELOAD = 1;

	localparam logic [1:0] IF_MODE_SLAVE_FIFO = 2'h3;
	localparam logic [1:0] TIMER_MODE_SPLIT   = 2'h3;
	localparam logic [1:0] SERIAL_MODE_SYNC   = 2'h0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:1] PORT_RESET  = 7'h00;
	localparam logic [1:0] MODE_RESET  = 2'h0;
	localparam logic [5:0] READY_RESET = 6'h00;

	// Alternate sources coming from the timers, serial ports and
	// waveform engine, all on the core clock
	typedef struct packed {
		logic [1:0] timer1Mode;
		logic       timer1Overflow;
		logic       timer1LowOverflow;
		logic       timer2Overflow;
		logic [1:0] serial0Mode;
		logic       serial0Data;
		logic [1:0] serial1Mode;
		logic       serial1Data;
		logic       waveformAddr8;
	} core_alt_type;

endpackage : port_e_mux_pkg

//--- hw/input_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser; a level is accepted once stages two and
// three agree, otherwise the previous accepted level is kept
module input_sync #(
	parameter int WIDTH = 13
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pinLevel,
	output logic      [WIDTH-1:0] level
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] level_q;

	initial begin
		if (WIDTH < 1) $error("input_sync: WIDTH must be positive");
	end

	// Shift chain
	always_ff @(posedge clk) begin
		if (reset) begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
		end else begin
			stage1_q <= pinLevel;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// Accept a bit only when the two later stages agree
	always_ff @(posedge clk) begin
		if (reset) begin
			level_q <= '0;
		end else begin
			level_q <= (stage2_q & stage3_q) |
				(level_q & (stage2_q | stage3_q));
		end
	end

	assign level = level_q;

endmodule : input_sync

//--- hw/edge_detect.sv
`timescale 1ns/1ns
// Rising and falling edge pulses of already synchronised levels
module edge_detect #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] prev_q;

	initial begin
		if (WIDTH < 1) $error("edge_detect: WIDTH must be positive");
	end

	// Previous level
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_q <= '0;
		end else begin
			prev_q <= level;
		end
	end

	// Edge pulses last one clock
	assign rise = level & ~prev_q;
	assign fall = ~level & prev_q;

endmodule : edge_detect

//--- verification/pin_partner.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far-side logic on the port and ready pins
// ----------------------------------------------------------------
module pin_partner (
	input  wire logic [7:1] portPinOut,
	input  wire logic [7:1] portPinOe,
	input  wire logic [7:1] extLevel,
	input  wire logic [5:0] readyDrive,
	output logic      [7:1] portPinIn,
	output logic      [5:0] readyPinIn
);
	// Pin level: the device wins where it drives, the far side elsewhere
	assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & extLevel);
	// Ready pins and strobes are driven by the far side only
	assign readyPinIn = readyDrive;
endmodule : pin_partner

//--- verification/testbench.sv
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin \
errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int LIMIT = 20000;
	logic                         clk, reset, psel, penable, pwrite;
	logic                         pready, pslverr, fifo, rdExp, wrExp;
	logic                         slaveReadStrobe, slaveWriteStrobe;
	logic                         irq6Request, timer2Reload;
	logic [7:0]                   paddr;
	logic [31:0]                  pwdata, prdata, rnd;
	port_e_mux_pkg::core_alt_type coreAlt;
	logic [7:1]                   portPinIn, portPinOut, portPinOe;
	logic [7:1]                   extLevel, sel, dir, outv;
	logic [7:1]                   oeExp, outExp, pinSeen;
	logic [5:0]                   readyExp;
	logic [5:0]                   readyPinIn, readyLevels, readyDrive;
	logic [1:0]                   mode, pol;
	int                           errors, totalChecks, seed, i;
	int                           cycles = 0;

	port_e_ready_pin_mux i_port_e_ready_pin_mux (.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .coreAlt(coreAlt), .portPinIn(portPinIn),
		.portPinOut(portPinOut), .portPinOe(portPinOe),
		.readyPinIn(readyPinIn), .readyLevels(readyLevels),
		.slaveReadStrobe(slaveReadStrobe),
		.slaveWriteStrobe(slaveWriteStrobe),
		.irq6Request(irq6Request), .timer2Reload(timer2Reload));
	pin_partner i_pin_partner (.portPinOut(portPinOut),
		.portPinOe(portPinOe), .extLevel(extLevel),
		.readyDrive(readyDrive), .portPinIn(portPinIn),
		.readyPinIn(readyPinIn));

	// Clock of 40 ns period
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	// One APB transfer; the request stands until pready is sampled high
	task automatic apbXfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apbXfer

	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apbXfer(1'h1, a, d, r, e);
	endtask : regWrite

	task automatic regCheck(input logic [7:0] a, input logic [31:0] ex,
		input logic er);
		logic [31:0] r;
		logic        e;
		apbXfer(1'h0, a, 32'h0, r, e);
		`CHECK("prdata", ex, r)
		`CHECK("pslverr", er, e)
	endtask : regCheck

	// Alternate output values expected from the core sources
	function automatic logic [7:1] altOut(port_e_mux_pkg::core_alt_type c);
		logic [7:1] o;
		o = 7'h00;
		o[1] = (c.timer1Mode == port_e_mux_pkg::TIMER_MODE_SPLIT) ?
			c.timer1LowOverflow : c.timer1Overflow;
		o[2] = c.timer2Overflow;
		o[3] = (c.serial0Mode == port_e_mux_pkg::SERIAL_MODE_SYNC) ?
			c.serial0Data : 1'h1;
		o[4] = (c.serial1Mode == port_e_mux_pkg::SERIAL_MODE_SYNC) ?
			c.serial1Data : 1'h1;
		o[7] = c.waveformAddr8;
		return o;
	endfunction : altOut

	function automatic logic [7:1] expOe();
		return (sel & 7'h4f) | (~sel & dir);
	endfunction : expOe

	function automatic logic [7:1] expOut();
		return (sel & altOut(coreAlt)) | (~sel & dir & outv);
	endfunction : expOut

	// Drive a pad level and count event pulses over a settled window
	task automatic edgeCheck(input int pin, input logic lvl,
		input int nIrq, input int nRel);
		int a, b;
		@(posedge clk);
		extLevel[pin] <= lvl;
		a = 0;
		b = 0;
		repeat (12) begin
			@(negedge clk);
			a += int'(irq6Request === 1'h1);
			b += int'(timer2Reload === 1'h1);
		end
		`CHECK("irq6Request", nIrq, a)
		`CHECK("timer2Reload", nRel, b)
	endtask : edgeCheck

	task automatic tally_and_finish();
		if (errors == 0 && totalChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 7;
		errors = 0;
		totalChecks = 0;
		reset = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		coreAlt = '0;
		extLevel = 7'h00;
		readyDrive = 6'h00;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		@(negedge clk);
		`CHECK("portPinOe", 7'h00, portPinOe)
		for (i = 0; i < 8; i++)
			if (8'(4 * i) != port_e_mux_pkg::GPIO_IN_OFS)
				regCheck(8'(4 * i), 32'h0, 1'h0);
		regCheck(8'h20, 32'h0, 1'h1);
		// Random pin configurations, all-alternate and all-port first
		for (i = 0; i < 24; i++) begin
			rnd = $random(seed);
			sel = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : rnd[7:1];
			dir = rnd[14:8];
			outv = rnd[21:15];
			regWrite(port_e_mux_pkg::ALT_SELECT_OFS, {24'h0, sel, 1'h0});
			regWrite(port_e_mux_pkg::GPIO_DIR_OFS, {24'h0, dir, 1'h0});
			regWrite(port_e_mux_pkg::GPIO_OUT_OFS, {24'h0, outv, 1'h0});
			regCheck(port_e_mux_pkg::ALT_SELECT_OFS, {24'h0, sel, 1'h0},
				1'h0);
			repeat (4) begin
				@(posedge clk);
				coreAlt <= port_e_mux_pkg::core_alt_type'(12'($random(seed)));
				@(posedge clk);
				@(negedge clk);
				oeExp = expOe();
				outExp = expOut() & oeExp;
				pinSeen = portPinOut & oeExp;
				`CHECK("portPinOe", oeExp, portPinOe)
				`CHECK("t1Pin", outExp[1], pinSeen[1])
				`CHECK("t2Pin", outExp[2], pinSeen[2])
				`CHECK("ser0Pin", outExp[3], pinSeen[3])
				`CHECK("ser1Pin", outExp[4], pinSeen[4])
				`CHECK("portPinOut", outExp, pinSeen)
			end
			@(posedge clk);
			extLevel <= rnd[28:22];
			repeat (8) @(posedge clk);
			regCheck(port_e_mux_pkg::GPIO_IN_OFS, {24'h0, (expOe() & expOut())
				| (~expOe() & extLevel), 1'h0}, 1'h0);
		end
		// Interrupt and reload edges
		regWrite(port_e_mux_pkg::ALT_SELECT_OFS, 32'h60);
		regWrite(port_e_mux_pkg::TIMER2_CTRL_OFS, 32'h0);
		@(posedge clk);
		extLevel <= 7'h00;
		repeat (10) @(posedge clk);
		regWrite(port_e_mux_pkg::EVENT_STATUS_OFS, 32'h3);
		edgeCheck(5, 1'h1, 1, 0);
		edgeCheck(5, 1'h0, 0, 0);
		edgeCheck(6, 1'h1, 0, 0);
		edgeCheck(6, 1'h0, 0, 0);
		regCheck(port_e_mux_pkg::EVENT_STATUS_OFS, 32'h1, 1'h0);
		regWrite(port_e_mux_pkg::EVENT_STATUS_OFS, 32'h1);
		regWrite(port_e_mux_pkg::TIMER2_CTRL_OFS,
			32'h1 << port_e_mux_pkg::T2_EXT_EN);
		edgeCheck(6, 1'h1, 0, 0);
		edgeCheck(6, 1'h0, 0, 1);
		regCheck(port_e_mux_pkg::EVENT_STATUS_OFS, 32'h2, 1'h0);
		regWrite(port_e_mux_pkg::ALT_SELECT_OFS, 32'h0);
		regWrite(port_e_mux_pkg::GPIO_DIR_OFS, 32'h0);
		edgeCheck(5, 1'h1, 0, 0);
		// Every interface mode and strobe polarity
		for (i = 0; i < 16; i++) begin
			mode = 2'(i);
			pol = 2'(i >> 2);
			regWrite(port_e_mux_pkg::IF_CONFIG_OFS, {30'h0, mode});
			regWrite(port_e_mux_pkg::FIFO_POLARITY_OFS, {28'h0, pol, 2'h0});
			@(posedge clk);
			readyDrive <= 6'($random(seed));
			repeat (8) @(posedge clk);
			@(negedge clk);
			fifo = (mode == port_e_mux_pkg::IF_MODE_SLAVE_FIFO);
			readyExp = fifo ? {readyDrive[5:2], 2'h0} : readyDrive;
			rdExp = fifo && readyDrive[0] == pol[1];
			wrExp = fifo && readyDrive[1] == pol[0];
			`CHECK("readyLevels", readyExp, readyLevels)
			`CHECK("slaveReadStrobe", rdExp, slaveReadStrobe)
			`CHECK("slaveWriteStrobe", wrExp, slaveWriteStrobe)
		end
		tally_and_finish();
	end
endmodule : testbench
